// *** common/cmc_map.svh ***
// Purpose: offsets, field positions and reset values of the mode control block
// Assumes: 32-bit APB words, byte addresses
// Notes:   included by its bare name
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH
`define CMC_CTRL_OFFSET   12'h000
`define CMC_ABORT_BIT     27
`define CMC_REQ_HI        26
`define CMC_REQ_LO        24
`define CMC_CUR_HI        23
`define CMC_CUR_LO        21
`define CMC_CAP_BIT       20
`define CMC_ON_BIT        15
`define CMC_IDLE_BIT      13
`define CMC_BUSY_BIT      11
`define CMC_FILT_HI       4
`define CMC_FILT_LO       0
`define CMC_MODE_RESET    3'h4
`define CMC_TMR_RESET     16'h0000
`endif

// *** common/cmc_pkg.sv ***
// Purpose: types shared by the mode control block
// Assumes: nothing
// Notes:   mode codes follow the three-bit mode field
package cmc_pkg;
   typedef enum logic [2:0] {
      CMC_NORMAL = 3'h0,
      CMC_DISABLE = 3'h1,
      CMC_LOOPBACK = 3'h2,
      CMC_LISTEN_ONLY = 3'h3,
      CMC_CONFIG = 3'h4,
      CMC_RSVD5 = 3'h5,
      CMC_RSVD6 = 3'h6,
      CMC_LISTEN_ALL = 3'h7
   } cmc_mode_e;
   // status reported by the protocol engine
   typedef struct packed {
      logic        bus_idle;
      logic        tx_pending;
      logic        rx_valid;
   } cmc_eng_s;
endpackage

// *** dv/can_module_mode_control_bench.sv ***
// Purpose: bench of cmc_ctrl
// Assumes: APB slave answers in its own time
// Notes: mode rows, then edge cases
`timescale 1ns/1ps
module can_module_mode_control_bench;
   logic pclk, presetn, psel, penable, pwrite, start_tx, busy_in, rx_req, pready, pslverr;
   logic er, abort_all_tx, module_on, stop_in_idle, rx_stamp_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] current_op_mode;
   logic [4:0] net_filter_bit_count;
   logic [15:0] rx_timestamp_timer, rx_stamp, t;
   cmc_pkg::cmc_eng_s eng;
   int err_count, num_checks, n;
   // each row: requested mode, filter count, mode expected in force afterwards
   logic [10:0] rows [6] = '{{3'h0, 5'h03, 3'h0}, {3'h1, 5'h05, 3'h1}, {3'h2, 5'h0A, 3'h2},
                             {3'h3, 5'h0C, 3'h3}, {3'h4, 5'h11, 3'h4}, {3'h7, 5'h1F, 3'h7}};
   cmc_ctrl i_cmc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .eng, .abort_all_tx, .current_op_mode, .module_on,
      .stop_in_idle, .net_filter_bit_count, .rx_timestamp_timer, .rx_stamp, .rx_stamp_valid);
   cmc_eng_model i_cmc_eng_model (.pclk, .presetn, .abort_all_tx, .start_tx, .busy_in,
      .rx_req, .eng);
   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // one APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait states are the slave's business; the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d bad %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      pclk = 0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      // the tests need fewer than two hundred cycles, so 4000 cycles mean a hang
      #20000;
      err_count++;
      report_and_stop;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, start_tx, busy_in, rx_req} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, 0, 0);
      chk(rd, 32'h0480_0000);
      $display("reset values done");
      foreach (rows[i]) begin
         apb(1, 0, {5'h0, rows[i][10:8], 19'h0, rows[i][7:3]});
         apb(0, 0, 0);
         chk(rd, {5'h0, rows[i][10:8], rows[i][2:0], 16'h0, rows[i][7:3]});
         chk(net_filter_bit_count, rows[i][7:3]);
      end
      for (int m = 5; m < 7; m++) begin
         apb(1, 0, {5'h0, m[2:0], 24'h0});
         apb(0, 0, 0);
         chk(rd, 32'h07E0_0000);
      end
      apb(1, 12'h004, 32'hFFFF_FFFF);
      chk(er, 1);
      apb(0, 12'h004, 0);
      chk({er, rd}, {1'b1, 32'h0});
      $display("modes done");
      busy_in <= 1'b1;
      apb(1, 0, 0);
      repeat (2) @(posedge pclk);
      chk(current_op_mode, 3'h7);
      busy_in <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(current_op_mode, 3'h0);
      start_tx <= 1'b1;
      @(posedge pclk);
      start_tx <= 1'b0;
      apb(1, 0, 32'h0800_0000);
      chk(abort_all_tx, 1);
      repeat (2) @(posedge pclk);
      chk({abort_all_tx, eng.tx_pending}, 2'b11);
      for (n = 0; abort_all_tx !== 1'b0 && n < 20; n++) @(posedge pclk);
      apb(0, 0, 0);
      chk({eng.tx_pending, rd}, 0);
      $display("abort done");
      apb(1, 0, 32'h0010_0000);
      t = rx_timestamp_timer;
      repeat (4) @(posedge pclk);
      chk(rx_timestamp_timer, t + 16'h4);
      rx_req <= 1'b1;
      @(posedge pclk);
      rx_req <= 1'b0;
      @(posedge pclk);
      t = rx_timestamp_timer;
      @(posedge pclk);
      chk({rx_stamp_valid, rx_stamp}, {1'b1, t});
      apb(1, 0, 0);
      t = rx_timestamp_timer;
      rx_req <= 1'b1;
      @(posedge pclk);
      rx_req <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({rx_stamp_valid, rx_timestamp_timer}, {1'b0, t});
      $display("stamp done");
      apb(1, 0, 32'h0000_A000);
      apb(0, 0, 0);
      chk(rd, 32'h0000_A800);
      chk(stop_in_idle, 1);
      busy_in <= 1'b1;
      apb(1, 0, 0);
      repeat (2) @(posedge pclk);
      chk(module_on, 1);
      busy_in <= 1'b0;
      for (n = 0; module_on !== 1'b0 && n < 20; n++) @(posedge pclk);
      chk({module_on, stop_in_idle}, 2'b00);
      $display("enable done");
      // reset in mid-run: mode and enable go back to their reset state
      apb(1, 0, 32'h0100_8000);
      presetn <= 1'b0;
      @(posedge pclk);
      chk({current_op_mode, module_on, abort_all_tx}, {3'h4, 2'b00});
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, 0, 0);
      chk(rd, 32'h0480_0000);
      $display("mid-run reset done");
      report_and_stop;
   end
endmodule

// *** dv/cmc_eng_model.sv ***
// Purpose: stand-in for the protocol engine at the far side of the control block
// Assumes: bench raises start_tx, busy_in and rx_req by non-blocking assignment
// Notes:   a pending transmission drains 8 cycles after the abort request is seen
`timescale 1ns/1ps
module cmc_eng_model (
   input  wire logic         pclk,         // block clock
   input  wire logic         presetn,      // async reset, active low
   input  wire logic         abort_all_tx, // abort request from the block
   input  wire logic         start_tx,     // bench queues a transmission
   input  wire logic         busy_in,      // bench holds the bus busy
   input  wire logic         rx_req,       // bench asks for one received message
   output cmc_pkg::cmc_eng_s eng           // status seen by the block
);
   logic [3:0] cnt_q;                      // abort drain count

   // idle level, rx pulse and pending transmission, all on pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eng   <= 3'h4;                    // bus idle, nothing pending
         cnt_q <= 4'h0;
      end else begin
         eng.bus_idle <= !busy_in;
         eng.rx_valid <= rx_req;
         if (start_tx) begin
            eng.tx_pending <= 1'b1;
         end else if (cnt_q == 4'h1) begin
            eng.tx_pending <= 1'b0;
         end
         // drain starts whenever the abort request stands with the count at zero and counts down to idle
         if (abort_all_tx && cnt_q == 4'h0) begin
            cnt_q <= 4'h8;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule

// *** hdl/cmc_ctrl.sv ***
// Purpose: CAN module control register, mode request/report, abort, time-stamp capture
// Assumes: protocol engine reports idle, pending tx and valid rx on pclk
// Notes:   single APB word at CMC_CTRL_OFFSET, zero wait states
`timescale 1ns/1ps
`include "cmc_map.svh"
module cmc_ctrl #(
   parameter int TMR_W = 16                        // time-stamp timer width
) (
   input  wire logic              pclk,            // 200 MHz clock
   input  wire logic              presetn,         // async reset, active low
   input  wire logic              psel,            // apb select
   input  wire logic              penable,         // apb access phase
   input  wire logic              pwrite,          // apb direction
   input  wire logic [11:0]       paddr,           // apb byte address
   input  wire logic [31:0]       pwdata,          // apb write data
   output logic      [31:0]       prdata,          // apb read data
   output logic                   pready,          // apb ready
   output logic                   pslverr,         // apb error
   input  wire cmc_pkg::cmc_eng_s eng,             // engine status
   output logic                   abort_all_tx,    // abort request to tx buffers
   output logic      [2:0]        current_op_mode, // mode in force
   output logic                   module_on,       // module enable to engine
   output logic                   stop_in_idle,    // stop-in-idle control
   output logic      [4:0]        net_filter_bit_count, // filter bit count
   output logic      [TMR_W-1:0]  rx_timestamp_timer,   // running timer
   output logic      [TMR_W-1:0]  rx_stamp,        // stamp stored with message
   output logic                   rx_stamp_valid   // stamp strobe, one cycle
);
   logic [2:0]       req_q;      // requested mode
   logic [2:0]       cur_q;      // current mode
   logic             abort_q;    // abort pending
   logic             cap_q;      // capture enable
   logic             on_q;       // module-on request
   logic             active_q;   // module active (busy flag)
   logic             idle_q;     // stop in idle
   logic [4:0]       filt_q;     // filter bit count
   logic [TMR_W-1:0] tmr_q;      // time-stamp timer
   logic [TMR_W-1:0] stamp_q;    // captured stamp
   logic             stv_q;      // stamp strobe
   logic [31:0]      rd_q;       // read data
   logic             rdy_q;      // ready
   logic             err_q;      // error

   // decode of the bus access
   // a write lands only at the access edge at which pready stands high
   wire setup_w   = psel & ~penable;
   wire hit_w     = paddr == `CMC_CTRL_OFFSET;
   wire wr_w      = psel & penable & rdy_q & pwrite & hit_w;
   wire [2:0] wreq_w = pwdata[`CMC_REQ_HI:`CMC_REQ_LO];
   wire rsvd_w    = (wreq_w == cmc_pkg::CMC_RSVD5) | (wreq_w == cmc_pkg::CMC_RSVD6);
   wire safe_w    = eng.bus_idle & ~eng.tx_pending;
   // read image of the control word
   wire [31:0] img_w = {4'h0, abort_q, req_q, cur_q, cap_q, 4'h0, on_q, 1'b0, idle_q,
                        1'b0, active_q, 6'h00, filt_q};

   // requested mode: reserved codes leave the field as it was
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= `CMC_MODE_RESET;
      end else if (wr_w && !rsvd_w) begin
         req_q <= wreq_w;
      end
   end

   // current mode follows request only at a safe point
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_q <= `CMC_MODE_RESET;
      end else if (cur_q != req_q && safe_w) begin
         cur_q <= req_q;
      end
   end

   // abort: set by software, cleared by hardware when nothing pending; set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_q <= 1'b0;
      end else if (wr_w && pwdata[`CMC_ABORT_BIT]) begin
         abort_q <= 1'b1;
      end else if (abort_q && !eng.tx_pending) begin
         abort_q <= 1'b0;
      end
   end

   // plain control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_q  <= 1'b0;
         on_q   <= 1'b0;
         idle_q <= 1'b0;
         filt_q <= 5'h00;
      end else if (wr_w) begin
         cap_q  <= pwdata[`CMC_CAP_BIT];
         on_q   <= pwdata[`CMC_ON_BIT];
         idle_q <= pwdata[`CMC_IDLE_BIT];
         filt_q <= pwdata[`CMC_FILT_HI:`CMC_FILT_LO];
      end
   end

   // active flag: rises with on, falls only once the transaction ends
   // software polls this flag after clearing on, so it must not fall mid-transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q <= 1'b0;
      end else if (on_q) begin
         active_q <= 1'b1;
      end else if (safe_w) begin
         active_q <= 1'b0;
      end
   end

   // time-stamp timer runs only while capture enabled
   // the stamp is the count seen at the rx edge; stopping the timer saves power
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_q   <= TMR_W'(`CMC_TMR_RESET);
         stamp_q <= TMR_W'(`CMC_TMR_RESET);
         stv_q   <= 1'b0;
      end else begin
         stv_q <= cap_q & eng.rx_valid;
         if (cap_q) begin
            tmr_q <= tmr_q + 1'b1;
         end
         if (cap_q && eng.rx_valid) begin
            stamp_q <= tmr_q;
         end
      end
   end

   // apb answer: zero wait states, unmapped reads zero with error
   // read data are the image at the setup edge and stand through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q  <= 32'h0000_0000;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         rdy_q <= setup_w;
         err_q <= setup_w & ~hit_w;
         rd_q  <= (setup_w && hit_w && !pwrite) ? img_w : 32'h0000_0000;
      end
   end

   assign prdata               = rd_q;
   assign pready               = rdy_q;
   assign pslverr              = err_q;
   assign abort_all_tx         = abort_q;
   assign current_op_mode      = cur_q;
   assign module_on            = active_q;
   assign stop_in_idle         = idle_q;
   assign net_filter_bit_count = filt_q;
   assign rx_timestamp_timer   = tmr_q;
   assign rx_stamp             = stamp_q;
   assign rx_stamp_valid       = stv_q;

   // checks: abort is set by software and held until the buffers drain
   abort_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_w && pwdata[`CMC_ABORT_BIT] |=> abort_q)
      else $error("abort not set");
   abort_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      abort_q && eng.tx_pending |=> abort_q)
      else $error("abort dropped while tx pending");
   abort_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      abort_q && !eng.tx_pending && !wr_w |=> !abort_q)
      else $error("abort not cleared");

   // checks: mode request and report
   rsvd_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_w && rsvd_w |=> $stable(req_q))
      else $error("reserved mode taken");
   req_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_w && !rsvd_w |=> req_q == $past(wreq_w))
      else $error("requested mode not stored");
   mode_safe_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(cur_q) |-> $past(safe_w) && cur_q == $past(req_q))
      else $error("mode changed unsafely");
   mode_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      !safe_w |=> $stable(cur_q))
      else $error("mode changed during a transaction");
   mode_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      cur_q != req_q && safe_w |=> cur_q == $past(req_q))
      else $error("mode not entered");

   // checks: time stamp
   stamp_take_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_q && eng.rx_valid |=> stv_q && stamp_q == $past(tmr_q))
      else $error("stamp not captured");
   timer_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cap_q |=> $stable(tmr_q) && !stv_q)
      else $error("timer ran while disabled");

   // checks: enable and busy flag
   on_active_a: assert property (@(posedge pclk) disable iff (!presetn)
      on_q |=> active_q)
      else $error("module not enabled");
   busy_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      active_q && !on_q && !safe_w |=> active_q)
      else $error("busy dropped early");
   busy_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !on_q && safe_w |=> !active_q)
      else $error("busy not released");

   // checks: bus answer, one cycle after the setup edge
   apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup_w |=> pready && pslverr == !$past(hit_w))
      else $error("bus access not answered");

   // main scenarios
   cv_abort: cover property (@(posedge pclk) abort_q ##1 !abort_q);
   cv_mode: cover property (@(posedge pclk) $changed(cur_q));
   cv_stamp: cover property (@(posedge pclk) stv_q);
   cv_busy: cover property (@(posedge pclk) active_q && !on_q ##1 !active_q);
   cv_rsvd: cover property (@(posedge pclk) wr_w && rsvd_w);
endmodule
